/* File: logic/core_clock_prescaler_lowpower_ctrl.sv */
// Clock control: periph clock source selection, low-power wait, prescaler, registers
`timescale 1ns/1ps
`default_nettype none
`include "clk_ctrl_defines.svh"
module core_clock_prescaler_lowpower_ctrl (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Clock source ticks, one cycle each, and the alternate clock presence level
  input wire logic osc_input_tick,
  input wire logic pll_tick,
  input wire logic alt_clock_tick,
  input wire logic alt_clock_present,
  // Loose control bits held elsewhere
  input wire logic [2:0] pll_div_field,
  input wire logic xtal_stop_en,
  input wire logic slow16_n,
  input wire logic pll_out_sel_wr,
  input wire logic pll_out_sel_wdata,
  // Core events
  input wire logic wfi_exec,
  input wire logic wake_irq,
  input wire logic halt_exec,
  input wire logic mem_wait,
  input wire logic bus_req,
  input wire logic stop_restart,
  input wire logic ext_int_n,
  // Clock outputs
  output logic periph_clock_tick,
  output logic core_clock,
  output logic core_clock_tick,
  // Status and control outputs
  output logic altclk_active,
  output logic pll_out_sel,
  output logic pll_on,
  output logic xtal_run,
  output logic soft_reset_req,
  output logic int_out_n,
  output var clk_ctrl_pkg::op_state_type op_state
);
  import clk_ctrl_pkg::*;

  prescale_if pif ();

  // Registers and operating state
  logic [7:0] mode_clock_divide_r;
  logic [7:0] mode_clock_divide_nxt;
  logic [7:0] clock_lowpower_control_r;
  logic [7:0] clock_lowpower_control_nxt;
  op_state_type state_r;
  op_state_type state_nxt;
  src_type src_r;
  src_type src_nxt;

  // Clock source selection and status flags
  logic ref_half_r;
  logic ref_half_nxt;
  logic periph_tick_r;
  logic periph_tick_nxt;
  logic alt_active_r;
  logic alt_active_nxt;
  logic pll_out_sel_r;
  logic pll_out_sel_nxt;
  logic pll_on_r;
  logic pll_on_nxt;
  logic xtal_run_r;
  logic xtal_run_nxt;

  // Reset request, interrupt and read data
  logic soft_reset_r;
  logic soft_reset_nxt;
  logic irq_n_r;
  logic irq_n_nxt;
  logic int_out_r;
  logic int_out_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;

  // Derived ticks and decoded conditions
  logic ref_tick;
  logic ref16_tick;
  logic alt16_tick;
  logic lp_wait;
  logic lp_enter;
  logic alt_req;
  logic slow_prev;
  logic slow_now;

  // Divide-by-16 of reference and alternate clocks
  tick_div16 #(.W(4)) u_ref16 (
    .clk(clk),
    .rst(rst),
    .tick_in(ref_tick),
    .tick_out(ref16_tick)
  );

  tick_div16 #(.W(4)) u_alt16 (
    .clk(clk),
    .rst(rst),
    .tick_in(alt_clock_tick),
    .tick_out(alt16_tick)
  );

  core_prescaler u_presc (
    .clk(clk),
    .rst(rst),
    .pif(pif.presc)
  );

  // Reference clock: oscillator input optionally halved
  assign ref_tick = mode_clock_divide_r[`REF_EN_A_BIT] ?
    (osc_input_tick && ref_half_r) : osc_input_tick;
  assign lp_wait = (state_r == ST_LPWAIT);
  assign lp_enter = (state_r == ST_RUN) && wfi_exec && !halt_exec &&
    clock_lowpower_control_r[`LOWPOWER_WFI_EN_BIT];
  assign alt_req = clock_lowpower_control_r[`ALTCLK_SEL_BIT] ||
    (lp_wait && clock_lowpower_control_r[`WFI_ALTCLK_SEL_BIT]);
  assign slow_prev = (src_r == SRC_ALT) || (src_r == SRC_ALT16) || (src_r == SRC_REF16);
  assign slow_now = (src_nxt == SRC_ALT) || (src_nxt == SRC_ALT16) || (src_nxt == SRC_REF16);

  // Prescaler link: periph tick, hold and divide setting
  assign pif.periph_tick = periph_tick_r;
  assign pif.hold = mem_wait || bus_req || (state_r != ST_RUN);
  assign pif.sel = mode_clock_divide_r[`PRESCALE_HI:`PRESCALE_LO];

  // Operating state: wait, low-power wait, halt
  always_comb begin
    state_nxt = state_r;
    soft_reset_nxt = 1'b0;
    unique case (state_r)
      ST_RUN: begin
        if (halt_exec) begin
          if (clock_lowpower_control_r[`HALT_RESET_EN_BIT]) begin
            soft_reset_nxt = 1'b1;
          end else begin
            state_nxt = ST_HALTED;
          end
        end else if (wfi_exec) begin
          state_nxt = clock_lowpower_control_r[`LOWPOWER_WFI_EN_BIT] ? ST_LPWAIT : ST_WAIT;
        end
      end
      ST_WAIT, ST_LPWAIT: begin
        if (wake_irq) begin
          state_nxt = ST_RUN;
        end
      end
      // Only a reset leaves halt
      ST_HALTED: state_nxt = ST_HALTED;
    endcase
  end

  // Register writes; the wait-time alternate request latches the select bit
  always_comb begin
    mode_clock_divide_nxt = mode_clock_divide_r;
    clock_lowpower_control_nxt = clock_lowpower_control_r;
    rdata_nxt = `READ_IDLE;
    if (reg_wr && reg_addr == `MODE_CLOCK_DIVIDE_ADDR) begin
      mode_clock_divide_nxt = reg_wdata;
    end
    if (reg_wr && reg_addr == `CLOCK_LOWPOWER_CONTROL_ADDR) begin
      clock_lowpower_control_nxt = reg_wdata;
    end
    // Hardware set wins over a same-cycle software clear
    if (lp_wait && clock_lowpower_control_r[`WFI_ALTCLK_SEL_BIT] && alt_active_r) begin
      clock_lowpower_control_nxt[`ALTCLK_SEL_BIT] = 1'b1;
    end
    // Read data stands one cycle, zero when idle or unmapped
    if (reg_rd && reg_addr == `MODE_CLOCK_DIVIDE_ADDR) begin
      rdata_nxt = mode_clock_divide_r;
    end else if (reg_rd && reg_addr == `CLOCK_LOWPOWER_CONTROL_ADDR) begin
      rdata_nxt = clock_lowpower_control_r;
    end
  end

  // Source selection, PLL, crystal and select flag
  always_comb begin
    // Halving phase toggles on each oscillator tick
    ref_half_nxt = osc_input_tick ? !ref_half_r : ref_half_r;
    // Switch refused without a real alternate clock
    alt_active_nxt = alt_req && alt_clock_present && (state_r != ST_HALTED);
    if (state_r == ST_HALTED) begin
      src_nxt = SRC_NONE;
    end else if (lp_wait) begin
      // Divide-by-16 inside low-power wait; slow16_n low also picks SRC_REF16 outside it when the alternate clock is not active
      src_nxt = alt_active_r ? SRC_ALT16 : SRC_REF16;
    end else if (alt_active_r) begin
      src_nxt = SRC_ALT;
    end else if (!slow16_n) begin
      src_nxt = SRC_REF16;
    end else if (pll_out_sel_r) begin
      src_nxt = SRC_PLL;
    end else begin
      src_nxt = SRC_REF;
    end
    // Tick of the source chosen last cycle, so a switch never splits a tick
    unique case (src_r)
      SRC_PLL: periph_tick_nxt = pll_tick;
      SRC_REF: periph_tick_nxt = ref_tick;
      SRC_REF16: periph_tick_nxt = ref16_tick;
      SRC_ALT: periph_tick_nxt = alt_clock_tick;
      SRC_ALT16: periph_tick_nxt = alt16_tick;
      default: periph_tick_nxt = 1'b0;
    endcase
    // Crystal stops in halt, otherwise only when the alternate clock is really running
    xtal_run_nxt = !((state_r == ST_HALTED) ||
      (xtal_stop_en && alt_active_r) ||
      (lp_wait && clock_lowpower_control_r[`WFI_ALTCLK_SEL_BIT] && alt_active_r));
    // PLL off for the off code, slow mode, low-power wait and halt
    pll_on_nxt = (pll_div_field != `PLL_DIV_OFF) && slow16_n && !lp_wait &&
      (state_r != ST_HALTED);
    pll_out_sel_nxt = pll_out_sel_wr ? pll_out_sel_wdata : pll_out_sel_r;
    // Stops an unlocked PLL from driving the system clock
    if ((pll_div_field == `PLL_DIV_OFF) || !xtal_run_r || lp_enter || lp_wait || !slow16_n) begin
      pll_out_sel_nxt = 1'b0;
    end
  end

  // Clock-unit interrupt: one low cycle per event, then routed by the source bit
  always_comb begin
    irq_n_nxt = !((slow_prev != slow_now) || stop_restart);
    int_out_nxt = clock_lowpower_control_r[`INT_SEL_BIT] ? irq_n_r : ext_int_n;
  end

  // All control state registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_clock_divide_r <= `MODE_CLOCK_DIVIDE_RST;
      clock_lowpower_control_r <= `CLOCK_LOWPOWER_CONTROL_RST;
      state_r <= ST_RUN;
      src_r <= SRC_REF;
      ref_half_r <= 1'b0;
      periph_tick_r <= 1'b0;
      alt_active_r <= 1'b0;
      pll_out_sel_r <= 1'b0;
      pll_on_r <= 1'b0;
      xtal_run_r <= 1'b1;
      soft_reset_r <= 1'b0;
      irq_n_r <= 1'b1;
      int_out_r <= 1'b1;
      rdata_r <= `READ_IDLE;
    end else begin
      mode_clock_divide_r <= mode_clock_divide_nxt;
      clock_lowpower_control_r <= clock_lowpower_control_nxt;
      state_r <= state_nxt;
      src_r <= src_nxt;
      ref_half_r <= ref_half_nxt;
      periph_tick_r <= periph_tick_nxt;
      alt_active_r <= alt_active_nxt;
      pll_out_sel_r <= pll_out_sel_nxt;
      pll_on_r <= pll_on_nxt;
      xtal_run_r <= xtal_run_nxt;
      soft_reset_r <= soft_reset_nxt;
      irq_n_r <= irq_n_nxt;
      int_out_r <= int_out_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // Outputs straight from flip-flops
  assign reg_rdata = rdata_r;
  assign periph_clock_tick = periph_tick_r;
  assign core_clock = pif.core_clock;
  assign core_clock_tick = pif.core_tick;
  assign altclk_active = alt_active_r;
  assign pll_out_sel = pll_out_sel_r;
  assign pll_on = pll_on_r;
  assign xtal_run = xtal_run_r;
  assign soft_reset_req = soft_reset_r;
  assign int_out_n = int_out_r;
  assign op_state = state_r;
endmodule
`default_nettype wire

/* File: logic/clk_ctrl_defines.svh */
// Register offsets, field positions and reset values of the clock control block
`ifndef CLK_CTRL_DEFINES_SVH
`define CLK_CTRL_DEFINES_SVH

// Register offsets on the register port
`define MODE_CLOCK_DIVIDE_ADDR 8'heb
`define CLOCK_LOWPOWER_CONTROL_ADDR 8'hf0

// Reset values
`define MODE_CLOCK_DIVIDE_RST 8'he0
`define CLOCK_LOWPOWER_CONTROL_RST 8'h00
`define READ_IDLE 8'h00

// mode_clock_divide fields
`define REF_EN_A_BIT 5
`define PRESCALE_HI 4
`define PRESCALE_LO 2

// clock_lowpower_control fields
`define INT_SEL_BIT 7
`define HALT_RESET_EN_BIT 3
`define ALTCLK_SEL_BIT 2
`define WFI_ALTCLK_SEL_BIT 1
`define LOWPOWER_WFI_EN_BIT 0

// PLL divider code that switches the PLL off
`define PLL_DIV_OFF 3'h7

// Prescaler and divide-by-16 counter constants
`define PRESCALE_ZERO 3'h0
`define PRESCALE_ONE 3'h1
`define DIV16_LAST 4'hf
`define DIV16_ZERO 4'h0

`endif

/* File: logic/clk_ctrl_pkg.sv */
// Types shared by the clock control modules
`default_nettype none
package clk_ctrl_pkg;

  // Operating state of the core
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_WAIT = 2'b01,
    ST_LPWAIT = 2'b10,
    ST_HALTED = 2'b11
  } op_state_type;

  // Source currently feeding periph_clock
  typedef enum logic [2:0] {
    SRC_PLL = 3'b000,
    SRC_REF = 3'b001,
    SRC_REF16 = 3'b010,
    SRC_ALT = 3'b011,
    SRC_ALT16 = 3'b100,
    SRC_NONE = 3'b101
  } src_type;

endpackage
`default_nettype wire

/* File: logic/prescale_if.sv */
// Link between the clock controller and the core-clock prescaler
`timescale 1ns/1ps
`default_nettype none
interface prescale_if;
  logic periph_tick;
  logic hold;
  logic [2:0] sel;
  logic core_tick;
  logic core_clock;

  modport ctrl (output periph_tick, output hold, output sel, input core_tick, input core_clock);
  modport presc (input periph_tick, input hold, input sel, output core_tick, output core_clock);
endinterface
`default_nettype wire

/* File: logic/tick_div16.sv */
// Divides a tick stream by a power of two, emitting one tick per wrap
`timescale 1ns/1ps
`default_nettype none
`include "clk_ctrl_defines.svh"
module tick_div16 #(
  parameter int W = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Tick in and divided tick out
  input wire logic tick_in,
  output logic tick_out
);
  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;
  logic tick_nxt;

  // Count input ticks, pulse on the last one of each group
  always_comb begin
    cnt_nxt = cnt_r;
    tick_nxt = 1'b0;
    if (tick_in) begin
      cnt_nxt = cnt_r + {{(W-1){1'b0}}, 1'b1};
      tick_nxt = (cnt_r == {W{1'b1}});
    end
  end

  // Counter and output pulse registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r <= '0;
      tick_out <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      tick_out <= tick_nxt;
    end
  end
endmodule
`default_nettype wire

/* File: logic/core_prescaler.sv */
// Core-clock prescaler: one low phase per output period, high phase stretched
`timescale 1ns/1ps
`default_nettype none
`include "clk_ctrl_defines.svh"
module core_prescaler (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Controller side
  prescale_if.presc pif
);
  logic [2:0] cnt_r;
  logic [2:0] cnt_nxt;
  logic [2:0] div_r;
  logic [2:0] div_nxt;
  logic tick_r;
  logic tick_nxt;
  logic low_r;
  logic low_nxt;
  logic high_r;
  logic high_nxt;

  // Advance only on periph ticks and never while held, so the clock idles high
  always_comb begin
    cnt_nxt = cnt_r;
    div_nxt = div_r;
    tick_nxt = 1'b0;
    low_nxt = 1'b0;
    if (pif.periph_tick && !pif.hold) begin
      if (cnt_r == div_r) begin
        cnt_nxt = `PRESCALE_ZERO;
        tick_nxt = 1'b1;
        div_nxt = pif.sel;
        // Next period of one cycle goes low at once
        low_nxt = (pif.sel == `PRESCALE_ZERO);
      end else begin
        cnt_nxt = cnt_r + `PRESCALE_ONE;
        // Low only in the last periph cycle of the period
        low_nxt = ((cnt_r + `PRESCALE_ONE) == div_r);
      end
    end else if (pif.periph_tick) begin
      low_nxt = 1'b0;
    end else begin
      low_nxt = low_r && !pif.hold;
    end
    // Registered level keeps the core clock output free of gate glitches
    high_nxt = !low_nxt;
  end

  // State registers; the core clock level resets high
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r <= `PRESCALE_ZERO;
      div_r <= `PRESCALE_ZERO;
      tick_r <= 1'b0;
      low_r <= 1'b0;
      high_r <= 1'b1;
    end else begin
      cnt_r <= cnt_nxt;
      div_r <= div_nxt;
      tick_r <= tick_nxt;
      low_r <= low_nxt;
      high_r <= high_nxt;
    end
  end

  assign pif.core_tick = tick_r;
  assign pif.core_clock = high_r;
endmodule
`default_nettype wire

/* File: tb/clk_src_model.sv */
// Tick sources standing in for oscillator, PLL and alternate clock
`timescale 1ns/1ps
`default_nettype none
module clk_src_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Alternate clock presence
  input wire logic alt_on,
  // Source ticks
  output logic osc_tick,
  output logic pll_tick,
  output logic alt_tick
);
  logic [1:0] cnt_r;
  // Free phase counter shared by the slow sources
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r <= 2'h0;
    end else begin
      cnt_r <= cnt_r + 2'h1;
    end
  end
  assign osc_tick = cnt_r[0];
  assign pll_tick = 1'b1;
  // Absent alternate clock stands still, so no stale tick leaks through
  assign alt_tick = alt_on && (cnt_r == 2'h3);
endmodule
`default_nettype wire

/* File: tb/clk_ctrl_monitor.sv */
// Port-level checks on the clock control block
`timescale 1ns/1ps
`default_nettype none
`include "clk_ctrl_defines.svh"
module clk_ctrl_monitor (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Watched inputs
  input wire logic alt_clock_present,
  input wire logic [2:0] pll_div_field,
  input wire logic slow16_n,
  input wire logic wfi_exec,
  input wire logic halt_exec,
  input wire logic mem_wait,
  input wire logic bus_req,
  // Watched outputs
  input wire logic periph_clock_tick,
  input wire logic core_clock,
  input wire logic core_clock_tick,
  input wire logic altclk_active,
  input wire logic pll_out_sel,
  input wire logic pll_on,
  input wire logic xtal_run,
  input var clk_ctrl_pkg::op_state_type op_state
);
  import clk_ctrl_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  core_tick_cause_a:
    assert property (core_clock_tick |-> $past(periph_clock_tick)) else $error("stray core tick");
  low_after_tick_a:
    assert property ($fell(core_clock) |-> $past(periph_clock_tick)) else $error("stray low");
  hold_high_a:
    assert property ((mem_wait || bus_req) && ($past(mem_wait) || $past(bus_req))
      |-> core_clock && !core_clock_tick) else $error("core clock not held");
  wait_frozen_a:
    assert property (op_state != ST_RUN && $past(op_state) != ST_RUN
      |-> core_clock && !core_clock_tick) else $error("core clock runs in wait");
  wfi_entry_a:
    assert property (op_state == ST_RUN && wfi_exec && !halt_exec
      |=> op_state inside {ST_WAIT, ST_LPWAIT}) else $error("wait not entered");
  lp_pll_off_a:
    assert property (op_state == ST_LPWAIT && $past(op_state) == ST_LPWAIT
      |-> !pll_on && !pll_out_sel) else $error("pll alive in low power");
  pll_off_code_a:
    assert property ($past(pll_div_field) == `PLL_DIV_OFF || !$past(slow16_n)
      |-> !pll_on && !pll_out_sel) else $error("pll not off");
  alt_needs_clock_a:
    assert property (altclk_active |-> $past(alt_clock_present)) else $error("alt without clock");
  halt_stop_a:
    assert property (op_state == ST_HALTED && $past(op_state) == ST_HALTED
      |-> !xtal_run && !pll_on) else $error("clocks alive in halt");
  xtal_stop_cause_a:
    assert property (!xtal_run && op_state != ST_HALTED
      |-> altclk_active || $past(altclk_active)) else $error("crystal stopped early");
endmodule
bind core_clock_prescaler_lowpower_ctrl clk_ctrl_monitor mon (.clk(clk), .rst(rst),
  .alt_clock_present(alt_clock_present), .pll_div_field(pll_div_field),
  .slow16_n(slow16_n), .wfi_exec(wfi_exec), .halt_exec(halt_exec), .mem_wait(mem_wait),
  .bus_req(bus_req), .periph_clock_tick(periph_clock_tick), .core_clock(core_clock),
  .core_clock_tick(core_clock_tick), .altclk_active(altclk_active),
  .pll_out_sel(pll_out_sel), .pll_on(pll_on), .xtal_run(xtal_run), .op_state(op_state));
`default_nettype wire

/* File: tb/tb_core_clock_prescaler_lowpower_ctrl.sv */
// Self-checking bench for the clock control block
`timescale 1ns/1ps
`default_nettype none
`include "clk_ctrl_defines.svh"
`define CHK(n, e, v) begin n_checks++; if ((v) !== (e)) begin mismatches++; \
  $display("Error %s expected %0h seen %0h", n, e, v); end end
module tb_core_clock_prescaler_lowpower_ctrl;
  import clk_ctrl_pkg::*;
  localparam logic [7:0] MODE = `MODE_CLOCK_DIVIDE_ADDR;
  localparam logic [7:0] CTL = `CLOCK_LOWPOWER_CONTROL_ADDR;
  // Stimulus, all given a value at time zero
  logic clk = 0, rst = 1, wr_s = 0, rd_s = 0, alt_p = 0, xs = 0, s16_n = 1, pw = 0;
  logic pd = 0, wait_for_interrupt = 0, wake = 0, halt = 0, mw = 0, br = 0, rs = 0, ext_n = 1;
  logic [7:0] a = 8'h00, d = 8'h00, q;
  logic [2:0] div = 3'h7;
  logic ot, pt, at, ptick, cclk, ctick, act, psel, pon, xrun, srst, irq_n;
  op_state_type st;
  int mismatches = 0, n_checks = 0, g, g2, k;
  clk_src_model src (.clk(clk), .rst(rst), .alt_on(alt_p), .osc_tick(ot), .pll_tick(pt),
    .alt_tick(at));
  core_clock_prescaler_lowpower_ctrl dut (.clk(clk), .rst(rst), .reg_addr(a), .reg_wdata(d),
    .reg_wr(wr_s), .reg_rd(rd_s), .reg_rdata(q), .osc_input_tick(ot), .pll_tick(pt),
    .alt_clock_tick(at), .alt_clock_present(alt_p), .pll_div_field(div), .xtal_stop_en(xs),
    .slow16_n(s16_n), .pll_out_sel_wr(pw), .pll_out_sel_wdata(pd), .wfi_exec(wait_for_interrupt),
    .wake_irq(wake), .halt_exec(halt), .mem_wait(mw), .bus_req(br), .stop_restart(rs),
    .ext_int_n(ext_n), .periph_clock_tick(ptick), .core_clock(cclk),
    .core_clock_tick(ctick), .altclk_active(act), .pll_out_sel(psel), .pll_on(pon),
    .xtal_run(xrun), .soft_reset_req(srst), .int_out_n(irq_n), .op_state(st));
  // 10 MHz clock
  initial forever #50 clk = ~clk;
  // Inputs move 1 ns after the edge so no race with the design's sampling
  task automatic step(input int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] ad, input logic [7:0] v);
    a = ad;
    d = v;
    wr_s = 1;
    step();
    wr_s = 0;
    step();
  endtask
  task automatic rd(input logic [7:0] ad, input logic [7:0] e);
    a = ad;
    rd_s = 1;
    step();
    rd_s = 0;
    `CHK("reg_rdata", e, q)
    step();
  endtask
  task automatic pulse(ref logic s);
    s = 1;
    step();
    s = 0;
    step();
  endtask
  // Periph tick spacing; the first two intervals, the first possibly partial, are skipped
  task automatic gap(output int n);
    repeat (2) begin
      for (n = 0; ptick !== 1'b1 && n < 3000; n++) step();
      step();
    end
    for (n = 1; ptick !== 1'b1 && n < 3000; n++) step();
  endtask
  // Periph ticks spanned by four core periods
  task automatic ratio(input int n);
    int c;
    int p;
    c = 0;
    p = 0;
    step(80);
    for (int i = 0; ctick !== 1'b1 && i < 500; i++) step();
    while (c < 4 && p < 500) begin
      p += (ptick === 1'b1);
      step();
      c += (ctick === 1'b1);
    end
    `CHK("periph per core", 4 * (n + 1), p)
  endtask
  task automatic lows(output int n);
    n = 0;
    repeat (20) begin
      n += (irq_n === 1'b0);
      step();
    end
  endtask
  // Core ticks or low core clock levels seen while the core clock is held
  task automatic held(output int n);
    step();
    n = 0;
    repeat (39) begin
      n += (ctick === 1'b1) + (cclk !== 1'b1);
      step();
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Watchdog, far beyond the few thousand cycles the tests need
  initial begin
    step(20000);
    mismatches++;
    test_done();
  end
  // Test sequence
  initial begin
    step(16);
    rst = 0;
    step();
    rd(MODE, `MODE_CLOCK_DIVIDE_RST);
    rd(CTL, `CLOCK_LOWPOWER_CONTROL_RST);
    rd(8'h42, `READ_IDLE);
    `CHK("pll_on", 1'b0, pon)
    gap(g);
    for (int n = 0; n < 8; n++) begin
      wr(MODE, {3'h7, 3'(n), 2'h0});
      ratio(n);
      gap(g2);
      `CHK("periph gap", g, g2)
    end
    mw = 1;
    held(k);
    `CHK("core_clock", 1'b1, cclk)
    `CHK("edges while held", 0, k)
    mw = 0;
    br = 1;
    held(k);
    `CHK("core_clock", 1'b1, cclk)
    `CHK("edges while held", 0, k)
    br = 0;
    wr(MODE, 8'hc0);
    gap(g2);
    `CHK("undivided gap", g / 2, g2)
    wr(MODE, 8'he0);
    // PLL on, selected, then switched off by the divider code
    div = 3'h3;
    step(2);
    `CHK("pll_on", 1'b1, pon)
    pd = 1;
    pulse(pw);
    `CHK("pll_out_sel", 1'b1, psel)
    gap(g2);
    `CHK("pll gap", 1, g2)
    div = 3'h7;
    step(2);
    `CHK("pll_out_sel", 1'b0, psel)
    `CHK("pll_on", 1'b0, pon)
    div = 3'h3;
    pulse(pw);
    wr(CTL, 8'h01);
    pulse(wait_for_interrupt);
    `CHK("op_state", ST_LPWAIT, st)
    `CHK("pll_out_sel", 1'b0, psel)
    `CHK("pll_on", 1'b0, pon)
    gap(g2);
    `CHK("lp gap", 16 * g, g2)
    pulse(wake);
    gap(g2);
    `CHK("run gap", g, g2)
    // Software lets the PLL settle before selecting it again
    step(50);
    pulse(pw);
    `CHK("pll_out_sel", 1'b1, psel)
    pd = 0;
    pulse(pw);
    wr(CTL, 8'h00);
    pulse(wait_for_interrupt);
    `CHK("op_state", ST_WAIT, st)
    gap(g2);
    `CHK("wait gap", g, g2)
    pulse(wake);
    // Alternate clock: refused while absent, then crystal stop
    wr(CTL, 8'h04);
    step(4);
    `CHK("altclk_active", 1'b0, act)
    alt_p = 1;
    step(4);
    `CHK("altclk_active", 1'b1, act)
    gap(g2);
    `CHK("alt gap", 4, g2)
    xs = 1;
    step(4);
    `CHK("xtal_run", 1'b0, xrun)
    xs = 0;
    wr(CTL, 8'h00);
    xs = 1;
    step(4);
    `CHK("xtal_run", 1'b1, xrun)
    xs = 0;
    wr(CTL, 8'h03);
    pulse(wait_for_interrupt);
    gap(g2);
    `CHK("alt16 gap", 64, g2)
    `CHK("xtal_run", 1'b0, xrun)
    pulse(wake);
    `CHK("altclk_active", 1'b1, act)
    rd(CTL, 8'h07);
    wr(CTL, 8'h00);
    // The alternate deselect event passes while the clock-unit interrupt is masked
    lows(k);
    `CHK("masked irq lows", 0, k)
    // Clock-unit interrupt, then masked
    wr(CTL, 8'h80);
    s16_n = 0;
    lows(k);
    `CHK("irq lows", 1, k)
    gap(g2);
    `CHK("slow16 gap", 16 * g, g2)
    rs = 1;
    step();
    rs = 0;
    lows(k);
    `CHK("irq lows", 1, k)
    wr(CTL, 8'h00);
    s16_n = 1;
    lows(k);
    `CHK("irq lows", 0, k)
    ext_n = 0;
    step(2);
    `CHK("int_out_n", 1'b0, irq_n)
    ext_n = 1;
    // Halt with and without reset enable
    wr(CTL, 8'h08);
    halt = 1;
    step();
    halt = 0;
    `CHK("soft_reset_req", 1'b1, srst)
    rst = 1;
    step(2);
    rst = 0;
    step();
    halt = 1;
    step();
    halt = 0;
    step(2);
    `CHK("op_state", ST_HALTED, st)
    `CHK("xtal_run", 1'b0, xrun)
    test_done();
  end
endmodule
`default_nettype wire
